//--- sim/core_model.sv
// Processor-side model that collects results from the datapath
`timescale 1ns/10ps
module core_model (
	input wire logic clk,
	input wire logic result_valid_ff,
	input wire logic [31:0] result_ff,
	input wire logic [31:0] cyc
);
	logic [31:0] got_d[$];
	logic [31:0] got_c[$];

	// Take each one-cycle result where it is settled, with its cycle
	always @(negedge clk) begin
		if (result_valid_ff === 1'b1) begin
			got_d.push_back(result_ff);
			got_c.push_back(cyc);
		end
	end
endmodule

//--- sim/mac_datapath_test.sv
// Self-checking bench of the multiply-accumulate datapath
`timescale 1ns/10ps
module mac_datapath_test;
	import mac_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic issue_valid = 1'b0;
	mac_op_t issue_op = OP_NOP;
	logic [31:0] ry_val = 32'h0;
	logic [31:0] rx_val = 32'h0;
	logic ry_upper = 1'b0;
	logic rx_upper = 1'b0;
	logic op_long = 1'b0;
	shift_t shift_sel = SH_NONE;
	logic [1:0] acc_sel = 2'h0;
	logic [1:0] acc_src = 2'h0;
	logic [31:0] ea_addr = 32'h0;
	logic mask_use = 1'b0;
	logic result_valid_ff;
	logic [31:0] result_ff;
	logic [31:0] addr_ff;
	logic [31:0] cyc = 32'h0;
	int miscompares = 0;
	int checks_done = 0;
	int seed = 74467;
	logic [31:0] exp_d[$];
	logic [31:0] exp_c[$];
	logic [47:0] acc_m[4];

	mac_datapath u_mac_datapath (.clk(clk), .sys_rst(sys_rst),
		.issue_valid(issue_valid), .issue_op(issue_op), .ry_val(ry_val),
		.rx_val(rx_val), .ry_upper(ry_upper), .rx_upper(rx_upper),
		.op_long(op_long), .shift_sel(shift_sel), .acc_sel(acc_sel),
		.acc_src(acc_src), .ea_addr(ea_addr), .mask_use(mask_use),
		.result_valid_ff(result_valid_ff), .result_ff(result_ff),
		.addr_ff(addr_ff));
	core_model u_core_model (.clk(clk), .result_valid_ff(result_valid_ff),
		.result_ff(result_ff), .cyc(cyc));

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'd20000) begin
			miscompares++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Operand as the unit sees it: half select, then sign or zero fill
	function automatic logic [63:0] opnd(logic [31:0] v, logic up,
		logic lng, logic uns);
		logic [31:0] w;
		w = lng ? v : (up ? {{16{v[31] & ~uns}}, v[31:16]}
			: {{16{v[15] & ~uns}}, v[15:0]});
		return uns ? {32'h0, w} : {{32{w[31]}}, w};
	endfunction

	// Low 40 product bits widened to 48
	function automatic logic [47:0] prod48(logic [63:0] a, logic [63:0] b,
		logic uns);
		logic [63:0] p;
		p = a * b;
		return uns ? {8'h0, p[39:0]} : {{8{p[39]}}, p[39:0]};
	endfunction

	// Fractional store: ties go to an even kept lsb
	function automatic logic [31:0] fst(logic [31:0] w, logic [7:0] l,
		logic ss, logic rs);
		logic [23:0] r;
		logic [15:0] k;
		if (ss) begin
			r = {w[15:0], l};
			k = w[31:16] + {15'h0, r > 24'h800000 ||
				(r == 24'h800000 && w[16])};
			return {{16{k[15]}}, k};
		end
		if (!rs) begin
			return w;
		end
		return w + {31'h0, l > 8'h80 || (l == 8'h80 && w[0])};
	endfunction

	// Fractional 32-bit product: top 40 of the doubled product, widened
	function automatic logic [47:0] fprod(logic [31:0] a, logic [31:0] b,
		logic rs);
		logic signed [63:0] p;
		logic [39:0] k;
		logic [23:0] d;
		p = $signed(a) * $signed(b);
		p = p <<< 1;
		k = p[63:24];
		d = p[23:0];
		if (rs && (d > 24'h800000 || (d == 24'h800000 && k[0]))) begin
			k = k + 40'h1;
		end
		return {{8{k[39]}}, k};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Drivers and comparisons
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic iss(input mac_op_t op, input logic [31:0] ry,
		input logic [1:0] sel, input logic rd, input logic [31:0] ex);
		issue_valid = 1'b1;
		issue_op = op;
		ry_val = ry;
		acc_sel = sel;
		if (rd) begin
			exp_d.push_back(ex);
			exp_c.push_back(cyc + 32'd4);
		end
		@(negedge clk);
	endtask

	task automatic idle(input int n);
		issue_valid = 1'b0;
		issue_op = OP_NOP;
		repeat (n) @(negedge clk);
	endtask

	task automatic drain(input string nm);
		idle(6);
		chk(u_core_model.got_d.size(), exp_d.size());
		while (exp_d.size() > 0 && u_core_model.got_d.size() > 0) begin
			chk(u_core_model.got_d.pop_front(), exp_d.pop_front());
			chk(u_core_model.got_c.pop_front(), exp_c.pop_front());
		end
		exp_d.delete();
		exp_c.delete();
		$display("Test %s finished", nm);
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] w;
		logic [31:0] m;
		logic [31:0] r;
		logic [7:0] lo;
		logic [7:0] lv;
		logic [47:0] p;
		logic uns;
		mac_op_t op;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		chk(addr_ff, 32'h0);
		for (int i = 0; i < 4; i++) begin
			iss(OP_ST_ACC, 32'h0, 2'(i), 1'b1, 32'h0);
		end
		iss(OP_ST_EXT01, 32'h0, 2'h0, 1'b1, 32'h0);
		iss(OP_ST_MASK, 32'h0, 2'h0, 1'b1, 32'hFFFFFFFF);
		// Extension pairs read back exactly what was just written
		w = $random(seed);
		iss(OP_LD_EXT01, w, 2'h0, 1'b0, 32'h0);
		iss(OP_ST_EXT01, 32'h0, 2'h0, 1'b1, w);
		w = $random(seed);
		iss(OP_LD_EXT23, w, 2'h0, 1'b0, 32'h0);
		iss(OP_ST_EXT23, 32'h0, 2'h0, 1'b1, w);
		drain("reset");
		// Back-to-back multiplies of random size, sign and halves
		for (int k = 0; k < 16; k++) begin
			r = $random(seed);
			{ry_upper, rx_upper, op_long} = r[2:0];
			op = r[3] ? OP_MULU : OP_MULS;
			w = $random(seed);
			rx_val = $random(seed);
			p = prod48(opnd(w, r[2], r[0], r[3]),
				opnd(rx_val, r[1], r[0], r[3]), 1'b0);
			iss(op, w, 2'h0, 1'b1, p[31:0]);
		end
		drain("multiply");
		// Integer accumulate in signed then unsigned mode
		for (int md = 0; md < 2; md++) begin
			uns = md[0];
			iss(OP_LD_STAT, {25'h0, uns, 6'h0}, 2'h0, 1'b0, 32'h0);
			idle(3);
			for (int i = 0; i < 4; i++) begin
				w = $random(seed);
				acc_m[i] = {16'h0, w};
				iss(OP_LD_ACC, w, 2'(i), 1'b0, 32'h0);
			end
			iss(OP_LD_EXT01, 32'h0, 2'h0, 1'b0, 32'h0);
			iss(OP_LD_EXT23, 32'h0, 2'h0, 1'b0, 32'h0);
			for (int k = 0; k < 12; k++) begin
				r = $random(seed);
				{ry_upper, rx_upper, op_long} = r[2:0];
				op = (!uns && r[3]) ? OP_MSAC : OP_MAC;
				w = $random(seed);
				rx_val = $random(seed);
				p = prod48(opnd(w, r[2], r[0], uns),
					opnd(rx_val, r[1], r[0], uns), uns);
				acc_m[r[5:4]] = op == OP_MAC ? acc_m[r[5:4]] + p
					: acc_m[r[5:4]] - p;
				iss(op, w, r[5:4], 1'b0, 32'h0);
			end
			{ry_upper, rx_upper, op_long} = 3'h0;
			rx_val = 32'h3;
			for (int h = 0; h < 3; h++) begin
				shift_sel = shift_t'(h);
				acc_m[0] = acc_m[0] + (h == 1 ? 48'd36 : (h == 2 ? 48'd9
					: 48'd18));
				iss(OP_MAC, 32'h6, 2'h0, 1'b0, 32'h0);
			end
			shift_sel = SH_NONE;
			acc_src = 2'h0;
			iss(OP_CP_ACC, 32'h0, 2'h3, 1'b0, 32'h0);
			acc_m[3] = acc_m[0];
			for (int i = 0; i < 4; i++) begin
				iss(OP_ST_ACC, 32'h0, 2'(i), 1'b1, acc_m[i][31:0]);
			end
			iss(OP_ST_EXT01, 32'h0, 2'h0, 1'b1,
				{acc_m[0][47:32], acc_m[1][47:32]});
			iss(OP_ST_EXT23, 32'h0, 2'h0, 1'b1,
				{acc_m[2][47:32], acc_m[3][47:32]});
			drain("accumulate");
		end
		// Fractional stores: truncate, round to 32 and to 16 bits
		for (int s = 0; s < 4; s++) begin
			m = {24'h0, 1'b0, s[1], 1'b1, s[0], 4'h0};
			iss(OP_LD_STAT, m, 2'h0, 1'b0, 32'h0);
			idle(3);
			iss(OP_ST_STAT, 32'h0, 2'h0, 1'b1, m);
			for (int j = 0; j < 6; j++) begin
				lv = (j % 3 == 0) ? 8'h7F : ((j % 3 == 1) ? 8'h80 : 8'h81);
				w = $random(seed) & 32'h3FFFFFFF;
				lo = lv;
				if (s[1]) begin
					w[15:0] = {lv, 8'h00};
					w[16] = j / 3;
					lo = 8'h00;
				end else begin
					w[0] = j / 3;
				end
				iss(OP_LD_ACC, w, 2'h0, 1'b0, 32'h0);
				iss(OP_LD_EXT01, {8'h00, lo, 16'h0}, 2'h0, 1'b0, 32'h0);
				iss(OP_ST_ACC, 32'h0, 2'h0, 1'b1, fst(w, lo, s[1], s[0]));
			end
			// Two 32-bit fractional accumulates, then a store
			op_long = 1'b1;
			iss(OP_LD_ACC, 32'h0, 2'h0, 1'b0, 32'h0);
			iss(OP_LD_EXT01, 32'h0, 2'h0, 1'b0, 32'h0);
			p = 48'h0;
			for (int k = 0; k < 2; k++) begin
				w = $random(seed);
				rx_val = $random(seed);
				p = p + fprod(w, rx_val, s[0]);
				iss(OP_MAC, w, 2'h0, 1'b0, 32'h0);
			end
			iss(OP_ST_ACC, 32'h0, 2'h0, 1'b1,
				fst(p[39:8], p[7:0], s[1], s[0]));
			op_long = 1'b0;
			drain("fraction");
		end
		// Signed saturation clamps an overflowing sum at the top
		iss(OP_LD_STAT, 32'h00000080, 2'h0, 1'b0, 32'h0);
		idle(3);
		iss(OP_LD_ACC, 32'hFFFFFFFF, 2'h1, 1'b0, 32'h0);
		iss(OP_LD_EXT01, 32'h00007FFF, 2'h0, 1'b0, 32'h0);
		{ry_upper, rx_upper, op_long} = 3'h0;
		rx_val = 32'h3;
		iss(OP_MAC, 32'h2, 2'h1, 1'b0, 32'h0);
		iss(OP_ST_ACC, 32'h0, 2'h1, 1'b1, SMAX[31:0]);
		iss(OP_ST_EXT01, 32'h0, 2'h0, 1'b1, {16'h0, SMAX[47:32]});
		drain("saturate");
		iss(OP_LD_STAT, 32'h0, 2'h0, 1'b0, 32'h0);
		// Address limit on combined loads
		m = $random(seed);
		iss(OP_LD_MASK, m, 2'h0, 1'b0, 32'h0);
		iss(OP_ST_MASK, 32'h0, 2'h0, 1'b1, {16'hFFFF, m[15:0]});
		idle(4);
		for (int k = 0; k < 10; k++) begin
			r = $random(seed);
			ea_addr = $random(seed);
			mask_use = r[0];
			@(negedge clk);
			chk(addr_ff, r[0] ? ea_addr & {16'hFFFF, m[15:0]} : ea_addr);
		end
		drain("address");
		print_verdict();
	end
endmodule

//--- src/mac_datapath.sv
// Four-stage multiply-accumulate datapath with four 48-bit accumulators
`timescale 1ns/10ps
// Summary of operation
// - Each accumulator is a 32-bit word plus 16 extension bits, 48 total
// - First extension pair: acc0 upper/lower high half, acc1 low half
// - Second extension pair: acc2 in high half, acc3 in low half
// - Integer multiplies take fixed latency, independent of data
// - Integer accumulate ops may scale product one bit left or right
// - Software-enabled saturation clamps accumulator overflow
// - Operands are 16 or 32 bits: signed, unsigned or fractional
// - Integer operands use the low 40 bits of the product
// - Fractional products keep top 40 of 64 bits, truncated or rounded
// - 40-bit product widened to 48: sign extend, or zero fill unsigned
// - Integer modes: accumulator is extension above the sum word
// - Fractional mode: upper byte, sum word, lower byte
// - An instruction field indexes one of four accumulators
// - Four-stage pipeline accepts one instruction every cycle
// - 16-bit operands pick upper or lower half of each register
// - Combined load may mask the operand address for circular queues
// - Fractional store rounds: 8 bits for 32-bit, 24 for 16-bit result
// - 32-bit fractional product truncated unless round select is set
// - Convergent rounding: ties at one half go to even kept lsb
// - Sign, fraction and round bits pick mode and rounding behaviour
// - Masked address is ANDed with all ones over the 16-bit limit
module mac_datapath (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic issue_valid,
	input wire mac_pkg::mac_op_t issue_op,
	input wire logic [31:0] ry_val,
	input wire logic [31:0] rx_val,
	input wire logic ry_upper,
	input wire logic rx_upper,
	input wire logic op_long,
	input wire mac_pkg::shift_t shift_sel,
	input wire logic [1:0] acc_sel,
	input wire logic [1:0] acc_src,
	input wire logic [31:0] ea_addr,
	input wire logic mask_use,
	output logic result_valid_ff,
	output logic [31:0] result_ff,
	output logic [31:0] addr_ff
);
	import mac_pkg::*;

	ctl_t ctl_ff [1:3];
	logic [3:1] vld_ff;
	logic [31:0] word_ff [NUM_ACC];
	logic [15:0] ext_ff [NUM_ACC];
	logic [31:0] status_ff;
	logic [15:0] mask_ff;
	logic [31:0] a_ff;
	logic [31:0] b_ff;
	logic sgn_ff;
	logic frac_ff;
	logic rnd_ff;
	shift_t sh_ff;
	logic is_mul;
	logic iss_frac;
	logic iss_sgn;
	ctl_t c;
	logic c_frac;
	logic c_sgn;
	logic [47:0] cur;
	logic [48:0] sum49;
	logic ovf;
	logic [47:0] nxt_acc;
	logic [63:0] rnd_val;
	logic [31:0] nxt_result;

	prod_if pif();

	product_unit u_prod (
		.clk(clk),
		.sys_rst(sys_rst),
		.pif(pif)
	);

	// Half-word choice and alignment of one source operand
	function automatic logic [31:0] pick(input logic [31:0] r,
		input logic up, input logic lng, input logic frac,
		input logic sgn);
		logic [15:0] h;
		h = up ? r[31:16] : r[15:0];
		if (lng) begin
			return r;
		end
		if (frac) begin
			return {h, 16'h0000};
		end
		return sgn ? {{16{h[15]}}, h} : {16'h0000, h};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Issue decode: mode comes from the status bits, multiplies are integer
	always_comb begin
		is_mul = (issue_op == OP_MULS) || (issue_op == OP_MULU);
		iss_frac = !is_mul && status_ff[ST_FRAC_BIT];
		if (issue_op == OP_MULS) begin
			iss_sgn = 1'b1;
		end else if (issue_op == OP_MULU) begin
			iss_sgn = 1'b0;
		end else begin
			iss_sgn = iss_frac || !status_ff[ST_SIGN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stage one: operand selection, one new instruction per cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_ff <= 32'h0;
			b_ff <= 32'h0;
			sgn_ff <= 1'b0;
			frac_ff <= 1'b0;
			rnd_ff <= 1'b0;
			sh_ff <= SH_NONE;
		end else begin
			a_ff <= pick(ry_val, ry_upper, op_long, iss_frac, iss_sgn);
			b_ff <= pick(rx_val, rx_upper, op_long, iss_frac, iss_sgn);
			sgn_ff <= iss_sgn;
			frac_ff <= iss_frac;
			rnd_ff <= iss_frac && status_ff[ST_ROUND_BIT];
			// Scale factor has no meaning for fractions or plain multiplies
			sh_ff <= (iss_frac || is_mul) ? SH_NONE : shift_sel;
		end
	end

	assign pif.a = a_ff;
	assign pif.b = b_ff;
	assign pif.is_signed = sgn_ff;
	assign pif.is_frac = frac_ff;
	assign pif.is_round = rnd_ff;
	assign pif.shift = sh_ff;

	// Control words march beside the product, no stall anywhere
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vld_ff <= 3'b000;
			for (int i = 1; i <= 3; i++) begin
				ctl_ff[i] <= '0;
			end
		end else begin
			vld_ff <= {vld_ff[2:1], issue_valid};
			ctl_ff[1] <= '{op: issue_op, sel: acc_sel, src: acc_src,
				data: ry_val, mode: status_ff[ST_SAT_BIT -: 4]};
			ctl_ff[2] <= ctl_ff[1];
			ctl_ff[3] <= ctl_ff[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stage four: accumulate, with optional saturation
	always_comb begin
		c = ctl_ff[3];
		c_frac = c.mode[M_FRAC];
		c_sgn = c_frac || !c.mode[M_SIGN];
		cur = acc_join(word_ff[c.sel], ext_ff[c.sel], c_frac);
		if (c.op == OP_MSAC) begin
			sum49 = {c_sgn & cur[47], cur} - {c_sgn & pif.prod[47], pif.prod};
		end else begin
			sum49 = {c_sgn & cur[47], cur} + {c_sgn & pif.prod[47], pif.prod};
		end
		ovf = c_sgn ? (sum49[48] != sum49[47]) : sum49[48];
		nxt_acc = sum49[47:0];
		if (ovf && c.mode[M_SAT]) begin
			if (c_sgn) begin
				nxt_acc = sum49[48] ? SMIN : SMAX;
			end else begin
				nxt_acc = (c.op == OP_MSAC) ? UMIN : UMAX;
			end
		end
	end

	// Read-back value, rounded in fractional mode for 16-bit stores or with round select set
	always_comb begin
		rnd_val = 64'h0;
		nxt_result = 32'h0;
		case (c.op)
			OP_MULS, OP_MULU: begin
				nxt_result = pif.prod[31:0];
			end
			OP_ST_ACC: begin
				if (!c_frac) begin
					nxt_result = cur[31:0];
				end else if (c.mode[M_SIGN]) begin
					rnd_val = rne_drop({{16{cur[47]}}, cur}, STORE16_DROP);
					nxt_result = {{16{rnd_val[15]}}, rnd_val[15:0]};
				end else if (c.mode[M_RND]) begin
					rnd_val = rne_drop({{16{cur[47]}}, cur}, STORE32_DROP);
					nxt_result = rnd_val[31:0];
				end else begin
					nxt_result = cur[39:8];
				end
			end
			OP_ST_EXT01: begin
				nxt_result = {ext_ff[0], ext_ff[1]};
			end
			OP_ST_EXT23: begin
				nxt_result = {ext_ff[2], ext_ff[3]};
			end
			OP_ST_STAT: begin
				nxt_result = status_ff;
			end
			OP_ST_MASK: begin
				nxt_result = {MASK_HI, mask_ff};
			end
			default: begin
				nxt_result = 32'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Accumulator array: word plus two extension bytes each
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_ACC; i++) begin
				word_ff[i] <= ACC_RESET;
				ext_ff[i] <= EXT_RESET;
			end
		end else if (vld_ff[3]) begin
			case (c.op)
				OP_MAC, OP_MSAC: begin
					{ext_ff[c.sel], word_ff[c.sel]} <= acc_split(nxt_acc, c_frac);
				end
				OP_LD_ACC: begin
					word_ff[c.sel] <= c.data;
				end
				OP_CP_ACC: begin
					word_ff[c.sel] <= word_ff[c.src];
					ext_ff[c.sel] <= ext_ff[c.src];
				end
				OP_LD_EXT01: begin
					ext_ff[0] <= c.data[31:16];
					ext_ff[1] <= c.data[15:0];
				end
				OP_LD_EXT23: begin
					ext_ff[2] <= c.data[31:16];
					ext_ff[3] <= c.data[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Status mode bits and address limit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_ff <= ST_RESET;
			mask_ff <= MASK_RESET;
		end else if (vld_ff[3]) begin
			if (c.op == OP_LD_STAT) begin
				status_ff <= c.data & ST_WMASK;
			end
			if (c.op == OP_LD_MASK) begin
				mask_ff <= c.data[15:0];
			end
		end
	end

	// Result port, one cycle per read instruction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_valid_ff <= 1'b0;
			result_ff <= 32'h0;
		end else begin
			result_valid_ff <= vld_ff[3] && is_read(c.op);
			result_ff <= nxt_result;
		end
	end

	// Operand address, optionally confined by the limit register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_ff <= 32'h0;
		end else if (mask_use) begin
			addr_ff <= ea_addr & {MASK_HI, mask_ff};
		end else begin
			addr_ff <= ea_addr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_read_latency: assert property (
		issue_valid && is_read(issue_op) |-> ##4 result_valid_ff)
		else $error("read result not after four cycles");

	a_no_stray_result: assert property (
		result_valid_ff |-> $past(issue_valid, 4) &&
		is_read($past(issue_op, 4)))
		else $error("result without matching issue");

	a_mask_address: assert property (
		mask_use |=> addr_ff == ($past(ea_addr) & {16'hFFFF, $past(mask_ff)}))
		else $error("masked address wrong");

	a_ext_pair_layout: assert property (
		vld_ff[3] && c.op == OP_LD_EXT01 ##1 vld_ff[3] &&
		c.op == OP_ST_EXT01 |=> result_ff == $past(c.data, 2))
		else $error("extension pair read-back differs");

	a_load_exact: assert property (
		vld_ff[3] && c.op == OP_LD_ACC |=>
		word_ff[$past(c.sel)] == $past(c.data))
		else $error("loaded word not exact");

	a_int_store: assert property (
		vld_ff[3] && c.op == OP_ST_ACC && !c_frac |=>
		result_valid_ff && result_ff == $past(cur[31:0]))
		else $error("integer store not the sum word");

	a_round_ties: assert property (
		vld_ff[3] && c.op == OP_ST_ACC && c_frac && !c.mode[M_SIGN] &&
		c.mode[M_RND] && cur[7:0] == 8'h80 |=>
		result_ff == $past(cur[39:8]) + {31'h0, $past(cur[8])})
		else $error("tie not rounded to even");

	a_round_above: assert property (
		vld_ff[3] && c.op == OP_ST_ACC && c_frac && !c.mode[M_SIGN] &&
		c.mode[M_RND] && cur[7:0] > 8'h80 |=>
		result_ff == $past(cur[39:8]) + 32'h1)
		else $error("above half not rounded up");

	c_back_to_back: cover property (issue_valid [*4]);
	c_saturate: cover property (vld_ff[3] && ovf && c.mode[M_SAT]);
	c_frac_store: cover property (result_valid_ff && $past(c_frac));

endmodule

//--- src/mac_pkg.sv
// Shared constants, types and helpers of the multiply-accumulate datapath
package mac_pkg;

	localparam int WORD_W = 32;
	localparam int EXT_W = 16;
	localparam int ACC_W = 48;
	localparam int PROD_W = 40;
	localparam int NUM_ACC = 4;
	localparam int STAGES = 4;

	// Status register bit positions and reset
	localparam int ST_SAT_BIT = 7;
	localparam int ST_SIGN_BIT = 6;
	localparam int ST_FRAC_BIT = 5;
	localparam int ST_ROUND_BIT = 4;
	localparam logic [31:0] ST_RESET = 32'h00000000;
	localparam logic [31:0] ST_WMASK = 32'h000000F0;

	// Mode nibble positions carried down the pipeline
	localparam int M_SAT = 3;
	localparam int M_SIGN = 2;
	localparam int M_FRAC = 1;
	localparam int M_RND = 0;

	// Address limit register and accumulator reset values
	localparam logic [15:0] MASK_HI = 16'hFFFF;
	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [31:0] ACC_RESET = 32'h00000000;
	localparam logic [15:0] EXT_RESET = 16'h0000;

	// Bits discarded by the rounding steps
	localparam logic [4:0] FRAC_DROP = 5'd24;
	localparam logic [4:0] STORE32_DROP = 5'd8;
	localparam logic [4:0] STORE16_DROP = 5'd24;

	// Saturation limits of the 48-bit accumulator
	localparam logic [47:0] SMAX = 48'h7FFFFFFFFFFF;
	localparam logic [47:0] SMIN = 48'h800000000000;
	localparam logic [47:0] UMAX = 48'hFFFFFFFFFFFF;
	localparam logic [47:0] UMIN = 48'h000000000000;

	typedef enum logic [3:0] {
		OP_NOP, OP_MAC, OP_MSAC, OP_MULS, OP_MULU, OP_LD_ACC, OP_ST_ACC,
		OP_CP_ACC, OP_LD_EXT01, OP_LD_EXT23, OP_ST_EXT01, OP_ST_EXT23,
		OP_LD_STAT, OP_ST_STAT, OP_LD_MASK, OP_ST_MASK
	} mac_op_t;

	typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT} shift_t;

	typedef struct packed {
		mac_op_t op;
		logic [1:0] sel;
		logic [1:0] src;
		logic [31:0] data;
		logic [3:0] mode;
	} ctl_t;

	// Convergent rounding: drop n low bits, ties go to even
	function automatic logic [63:0] rne_drop(input logic [63:0] v,
		input logic [4:0] n);
		logic [63:0] kept;
		logic [63:0] rem;
		logic [63:0] half;
		kept = $signed(v) >>> n;
		rem = v & ((64'h1 << n) - 64'h1);
		half = 64'h1 << (n - 5'h1);
		if (rem > half || (rem == half && kept[0])) begin
			kept = kept + 64'h1;
		end
		return kept;
	endfunction

	// Build the 48-bit accumulator from its stored word and extension
	function automatic logic [47:0] acc_join(input logic [31:0] w,
		input logic [15:0] e, input logic frac);
		return frac ? {e[15:8], w, e[7:0]} : {e, w};
	endfunction

	// Split a 48-bit accumulator back into {extension, word}
	function automatic logic [47:0] acc_split(input logic [47:0] a,
		input logic frac);
		return frac ? {a[47:40], a[7:0], a[39:8]} : a;
	endfunction

	function automatic logic is_read(input mac_op_t op);
		return op inside {OP_MULS, OP_MULU, OP_ST_ACC, OP_ST_EXT01,
			OP_ST_EXT23, OP_ST_STAT, OP_ST_MASK};
	endfunction

endpackage

//--- src/prod_if.sv
// Operand and product signals between the pipeline and the product unit
`timescale 1ns/10ps
interface prod_if;
	import mac_pkg::*;
	logic [31:0] a;
	logic [31:0] b;
	logic is_signed;
	logic is_frac;
	logic is_round;
	shift_t shift;
	logic [47:0] prod;
	modport src(output a, b, is_signed, is_frac, is_round, shift,
		input prod);
	modport unit(input a, b, is_signed, is_frac, is_round, shift,
		output prod);
endinterface

//--- src/product_unit.sv
// Multiplier stages two and three: full product, reduction, extension
`timescale 1ns/10ps
module product_unit (
	input wire logic clk,
	input wire logic sys_rst,
	prod_if.unit pif
);
	import mac_pkg::*;

	logic [63:0] p_ff;
	logic sgn_ff;
	logic frac_ff;
	logic rnd_ff;
	shift_t sh_ff;
	logic signed [65:0] full;
	logic [63:0] fp;
	logic [63:0] red;
	logic [39:0] p40;
	logic [47:0] ext;
	logic [39:0] a40;
	logic [39:0] b40;

	////////////////////////////////////////////////////////////////////
	// Stage two: fixed-latency 33x33 multiply, no early exit
	assign full = $signed({pif.is_signed & pif.a[31], pif.a}) *
		$signed({pif.is_signed & pif.b[31], pif.b});

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			p_ff <= 64'h0;
			sgn_ff <= 1'b0;
			frac_ff <= 1'b0;
			rnd_ff <= 1'b0;
			sh_ff <= SH_NONE;
		end else begin
			p_ff <= full[63:0];
			sgn_ff <= pif.is_signed;
			frac_ff <= pif.is_frac;
			rnd_ff <= pif.is_round;
			sh_ff <= pif.shift;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stage three: reduce to 40 bits, widen to 48, optional scale
	always_comb begin
		fp = p_ff << 1;
		red = rnd_ff ? rne_drop(fp, FRAC_DROP) : (fp >> FRAC_DROP);
		p40 = frac_ff ? red[39:0] : p_ff[39:0];
		ext = sgn_ff ? {{8{p40[39]}}, p40} : {8'h00, p40};
		if (sh_ff == SH_LEFT) begin
			ext = ext << 1;
		end else if (sh_ff == SH_RIGHT) begin
			ext = sgn_ff ? 48'($signed(ext) >>> 1) : (ext >> 1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pif.prod <= 48'h0;
		end else begin
			pif.prod <= ext;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the product path
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Operands widened to 40 bits, so the low product bits keep the sign
	assign a40 = pif.is_signed ? {{8{pif.a[31]}}, pif.a} : {8'h00, pif.a};
	assign b40 = pif.is_signed ? {{8{pif.b[31]}}, pif.b} : {8'h00, pif.b};

	a_int_low_bits: assert property (
		!pif.is_frac && pif.shift == SH_NONE |-> ##2
		pif.prod[39:0] == 40'($past(a40, 2) * $past(b40, 2)))
		else $error("integer product low 40 bits wrong");

	a_unsigned_zero_fill: assert property (
		!pif.is_signed |-> ##2 pif.prod[47:41] == 7'h00)
		else $error("unsigned product not zero filled");

endmodule
